// ### hdl/uart_port.sv
// serial port core: parity, receive errors, transmit fifo and interrupts
//
// Functional notes
// - one parity setting, readable in the control register, drives both send and check.
// - forced-one and forced-zero settings send and expect a constant parity bit.
// - framing, parity, break and overrun flags are read together from one register.
// - each received character carries its own four error bits matching the status flags.
// - overrun sets in the status register the moment the character is lost.
// - one write clears all four error flags; a new error interrupt needs a cleared flag.
// - a control bit turns smart-card mode on and off.
// - a readable flag shows free space in the transmit fifo, false only when full.
// - in fifo-level mode the transmit interrupt fires when the level falls past the threshold.
// - in end-of-transmission mode it fires when the fifo is empty and the last stop bit is out.
// - the transmit interrupt mode is a readable and writable control bit.
// - every interrupt source has an enable; raw and masked status are both readable.
// - software clears interrupt sources one by one by writing a clear register.
//
// Local design decisions: register access over AHB-Lite and the address map.
`timescale 1ns/100ps
module uart_port
    import uart_pkg::*;
(
    // clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RESET_I,
    // ahb-lite slave
    input  wire logic        HSEL_I,
    input  wire logic [31:0] HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic [31:0] HWDATA_I,
    input  wire logic        HREADY_I,
    output logic      [31:0] HRDATA_O,
    output logic             HREADYOUT_O,
    output logic             HRESP_O,
    // serial line and interrupt
    input  wire logic        RX_I,
    output logic             TX_O,
    output logic             IRQ_O
);

    typedef enum logic [2:0] {
        T_IDLE = 3'b000, T_LOAD = 3'b001, T_START = 3'b010,
        T_DATA = 3'b011, T_PAR  = 3'b100, T_STOP  = 3'b101
    } tx_state_type;

    typedef enum logic [2:0] {
        R_IDLE = 3'b000, R_START = 3'b001, R_DATA = 3'b010,
        R_PAR  = 3'b011, R_STOP  = 3'b100
    } rx_state_type;

    function automatic logic parity_bit(parity_type mode, logic [7:0] d);
        case (mode)
            parity_even:       parity_bit = ^d;
            parity_odd:        parity_bit = ~^d;
            parity_forced_one: parity_bit = 1'b1;
            default:           parity_bit = 1'b0;
        endcase
    endfunction : parity_bit

    // ----------------------------------------------------------------
    // registers and bus slave
    // ----------------------------------------------------------------
    parity_type         ctrl_par, next_ctrl_par;
    logic               smart, next_smart;
    txint_type          txint_mode, next_txint_mode;
    logic [15:0]        baud, next_baud;
    logic [3:0]         thr, next_thr;
    logic [5:0]         ien, next_ien, ris, next_ris, ev;
    logic [3:0]         rxerr, next_rxerr, rx_herr, next_rx_herr;
    logic [7:0]         rx_hold, next_rx_hold, wr_addr, next_wr_addr;
    logic               rx_full, next_rx_full, wr_pend, next_wr_pend;
    logic [31:0]        next_hrdata;
    logic               next_irq;
    logic [FIFO_AW-1:0] wptr, next_wptr, rptr, next_rptr;
    logic [4:0]         count, next_count;
    logic               acc, rx_pop, push, overrun, tx_space, wr_rxerr;
    logic               tx_pop, tx_done, rx_deliver;
    logic [2:0]         rx_errs;
    logic [7:0]         rx_char, tx_rdata;
    tx_state_type       tx_state, next_tx_state;

    assign acc      = HSEL_I & HTRANS_I[1] & HREADY_I;
    assign tx_space = (count != FIFO_DEPTH);
    assign rx_pop   = acc & ~HWRITE_I & (HADDR_I[7:0] == ADDR_DATA);
    assign push     = wr_pend & (wr_addr == ADDR_DATA) & tx_space;
    assign wr_rxerr = wr_pend & (wr_addr == ADDR_RXERR);
    assign overrun  = rx_deliver & rx_full & ~rx_pop;

    always_comb
    begin
        next_ctrl_par   = ctrl_par;
        next_smart      = smart;
        next_txint_mode = txint_mode;
        next_baud       = baud;
        next_thr        = thr;
        next_ien        = ien;
        next_rx_hold    = rx_hold;
        next_rx_herr    = rx_herr;
        next_rx_full    = rx_full;
        next_rxerr      = rxerr;
        next_wr_pend    = acc & HWRITE_I;
        next_wr_addr    = acc ? HADDR_I[7:0] : wr_addr;
        next_hrdata     = HRDATA_O;
        next_wptr       = push ? wptr + 1'b1 : wptr;
        next_rptr       = tx_pop ? rptr + 1'b1 : rptr;
        next_count      = count + 5'(push) - 5'(tx_pop);
        ev              = 6'h00;
        // read data registered in the address phase, ready in the data phase
        if (acc & ~HWRITE_I)
        begin
            case (HADDR_I[7:0])
                ADDR_DATA:  next_hrdata = {20'h0, rx_herr, rx_hold};
                ADDR_RXERR: next_hrdata = {28'h0, rxerr};
                ADDR_CTRL:  next_hrdata = {27'h0, txint_mode, smart, ctrl_par};
                ADDR_BAUD:  next_hrdata = {16'h0, baud};
                ADDR_FLAG:  next_hrdata = {23'h0, count, rx_full,
                                           (tx_state != T_IDLE), (count == 5'h00), tx_space};
                ADDR_THR:   next_hrdata = {28'h0, thr};
                ADDR_RIS:   next_hrdata = {26'h0, ris};
                ADDR_IEN:   next_hrdata = {26'h0, ien};
                ADDR_MIS:   next_hrdata = {26'h0, ris & ien};
                default:    next_hrdata = 32'h0000_0000;
            endcase
        end
        if (wr_pend)
        begin
            case (wr_addr)
                ADDR_CTRL:
                begin
                    next_ctrl_par   = parity_type'(HWDATA_I[CTRL_PAR_LSB +: 3]);
                    next_smart      = HWDATA_I[CTRL_SMART];
                    next_txint_mode = txint_type'(HWDATA_I[CTRL_TXINT]);
                end
                ADDR_BAUD: next_baud = HWDATA_I[15:0];
                ADDR_THR:  next_thr  = HWDATA_I[3:0];
                ADDR_IEN:  next_ien  = HWDATA_I[5:0];
                default:   next_ien  = ien;
            endcase
        end
        // receive holding register and error flags; a new error beats the clear
        if (wr_rxerr)
        begin
            next_rxerr = 4'h0;
        end
        if (rx_pop)
        begin
            next_rx_full = 1'b0;
        end
        if (overrun)
        begin
            next_rxerr[rx_overrun_error]   = 1'b1;
            next_rx_herr[rx_overrun_error] = 1'b1;
        end
        else if (rx_deliver)
        begin
            next_rx_hold = rx_char;
            next_rx_herr = {1'b0, rx_errs};
            next_rx_full = 1'b1;
        end
        if (rx_deliver)
        begin
            next_rxerr[2:0] = next_rxerr[2:0] | rx_errs;
        end
        // interrupt events; error sources only fire from a cleared flag
        ev[INT_RX] = rx_deliver & ~overrun;
        ev[INT_FE] = rx_deliver & rx_errs[rx_framing_error] & ~rxerr[rx_framing_error];
        ev[INT_PE] = rx_deliver & rx_errs[rx_parity_error] & ~rxerr[rx_parity_error];
        ev[INT_BE] = rx_deliver & rx_errs[rx_break_error] & ~rxerr[rx_break_error];
        ev[INT_OE] = overrun & ~rxerr[rx_overrun_error];
        if (txint_mode == txint_end_of_transmission)
        begin
            ev[INT_TX] = tx_done & (count == 5'h00) & ~push;
        end
        else
        begin
            ev[INT_TX] = (count > {1'b0, thr}) & (next_count <= {1'b0, thr});
        end
        next_ris = ris | ev;
        if (wr_pend && wr_addr == ADDR_ICLR)
        begin
            next_ris = (ris & ~HWDATA_I[5:0]) | ev;
        end
        next_irq = |(next_ris & next_ien);
    end

    always_ff @(posedge CLK_I)
    begin
        if (RESET_I)
        begin
            ctrl_par    <= parity_none;
            smart       <= 1'b0;
            txint_mode  <= txint_fifo_level;
            baud        <= BAUD_RESET;
            thr         <= THR_RESET;
            ien         <= 6'h00;
            ris         <= 6'h00;
            rxerr       <= 4'h0;
            rx_herr     <= 4'h0;
            rx_hold     <= 8'h00;
            rx_full     <= 1'b0;
            wr_pend     <= 1'b0;
            wr_addr     <= 8'h00;
            wptr        <= '0;
            rptr        <= '0;
            count       <= 5'h00;
            HRDATA_O    <= 32'h0000_0000;
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= 1'b0;
            IRQ_O       <= 1'b0;
        end
        else
        begin
            ctrl_par    <= next_ctrl_par;
            smart       <= next_smart;
            txint_mode  <= next_txint_mode;
            baud        <= next_baud;
            thr         <= next_thr;
            ien         <= next_ien;
            ris         <= next_ris;
            rxerr       <= next_rxerr;
            rx_herr     <= next_rx_herr;
            rx_hold     <= next_rx_hold;
            rx_full     <= next_rx_full;
            wr_pend     <= next_wr_pend;
            wr_addr     <= next_wr_addr;
            wptr        <= next_wptr;
            rptr        <= next_rptr;
            count       <= next_count;
            HRDATA_O    <= next_hrdata;
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= 1'b0;
            IRQ_O       <= next_irq;
        end
    end

    uart_tx_mem u_mem (
        .clk_i   (CLK_I),
        .we_i    (push),
        .waddr_i (wptr),
        .wdata_i (HWDATA_I[7:0]),
        .raddr_i (rptr),
        .rdata_o (tx_rdata)
    );

    // ----------------------------------------------------------------
    // transmitter
    // ----------------------------------------------------------------
    logic [15:0]  tx_cnt, next_tx_cnt;
    logic [7:0]   tx_sh, next_tx_sh;
    logic [2:0]   tx_idx, next_tx_idx;
    logic         tx_parb, next_tx_parb, tx_paron, next_tx_paron, next_txd;

    always_comb
    begin
        next_tx_state = tx_state;
        next_tx_cnt   = (tx_cnt == 16'h0000) ? baud - 16'h0001 : tx_cnt - 16'h0001;
        next_tx_sh    = tx_sh;
        next_tx_idx   = tx_idx;
        next_tx_parb  = tx_parb;
        next_tx_paron = tx_paron;
        next_txd      = TX_O;
        tx_pop        = 1'b0;
        tx_done       = 1'b0;
        case (tx_state)
            T_IDLE:
            begin
                next_txd = 1'b1;
                if (count != 5'h00)
                begin
                    next_tx_state = T_LOAD;
                end
            end
            T_LOAD:
            begin
                tx_pop        = 1'b1;
                next_tx_sh    = tx_rdata;
                next_tx_parb  = parity_bit(ctrl_par, tx_rdata);
                next_tx_paron = (ctrl_par != parity_none);
                next_tx_cnt   = baud - 16'h0001;
                next_txd      = 1'b0;
                next_tx_state = T_START;
            end
            T_START:
            begin
                if (tx_cnt == 16'h0000)
                begin
                    next_txd      = tx_sh[0];
                    next_tx_idx   = 3'h0;
                    next_tx_state = T_DATA;
                end
            end
            T_DATA:
            begin
                if (tx_cnt == 16'h0000)
                begin
                    next_tx_sh = {1'b0, tx_sh[7:1]};
                    if (tx_idx != 3'h7)
                    begin
                        next_tx_idx = tx_idx + 3'h1;
                        next_txd    = tx_sh[1];
                    end
                    else if (tx_paron)
                    begin
                        next_txd      = tx_parb;
                        next_tx_state = T_PAR;
                    end
                    else
                    begin
                        next_txd      = 1'b1;
                        next_tx_idx   = 3'h0;
                        next_tx_state = T_STOP;
                    end
                end
            end
            T_PAR:
            begin
                if (tx_cnt == 16'h0000)
                begin
                    next_txd      = 1'b1;
                    next_tx_idx   = 3'h0;
                    next_tx_state = T_STOP;
                end
            end
            T_STOP:
            begin
                if (tx_cnt == 16'h0000)
                begin
                    // smart-card mode adds a second stop bit as guard time
                    if (smart && tx_idx == 3'h0)
                    begin
                        next_tx_idx = 3'h1;
                    end
                    else
                    begin
                        tx_done       = 1'b1;
                        next_tx_state = T_IDLE;
                    end
                end
            end
            default: next_tx_state = T_IDLE;
        endcase
    end

    always_ff @(posedge CLK_I)
    begin
        if (RESET_I)
        begin
            tx_state <= T_IDLE;
            tx_cnt   <= 16'h0000;
            tx_sh    <= 8'h00;
            tx_idx   <= 3'h0;
            tx_parb  <= 1'b0;
            tx_paron <= 1'b0;
            TX_O     <= 1'b1;
        end
        else
        begin
            tx_state <= next_tx_state;
            tx_cnt   <= next_tx_cnt;
            tx_sh    <= next_tx_sh;
            tx_idx   <= next_tx_idx;
            tx_parb  <= next_tx_parb;
            tx_paron <= next_tx_paron;
            TX_O     <= next_txd;
        end
    end

    // ----------------------------------------------------------------
    // receiver
    // ----------------------------------------------------------------
    rx_state_type rx_state, next_rx_state;
    logic [15:0]  rx_cnt, next_rx_cnt;
    logic [2:0]   rx_idx, next_rx_idx;
    logic         rx_prev, rx_zero, next_rx_zero, rx_perr, next_rx_perr;
    logic [7:0]   rx_sh, next_rx_sh;
    logic         rx_tick;

    assign rx_tick = (rx_cnt == 16'h0000);
    assign rx_char = rx_sh;

    always_comb
    begin
        next_rx_state = rx_state;
        next_rx_cnt   = rx_tick ? baud - 16'h0001 : rx_cnt - 16'h0001;
        next_rx_idx   = rx_idx;
        next_rx_sh    = rx_sh;
        next_rx_zero  = rx_zero;
        next_rx_perr  = rx_perr;
        rx_deliver    = 1'b0;
        rx_errs       = 3'h0;
        case (rx_state)
            R_IDLE:
            begin
                if (rx_prev && !RX_I)
                begin
                    // the count runs down to zero inclusive: one less lands mid-bit
                    next_rx_cnt   = {1'b0, baud[15:1]} - 16'h0001;
                    next_rx_state = R_START;
                end
            end
            R_START:
            begin
                if (rx_tick)
                begin
                    next_rx_idx   = 3'h0;
                    next_rx_zero  = 1'b1;
                    next_rx_perr  = 1'b0;
                    next_rx_state = RX_I ? R_IDLE : R_DATA;
                end
            end
            R_DATA:
            begin
                if (rx_tick)
                begin
                    next_rx_sh   = {RX_I, rx_sh[7:1]};
                    next_rx_zero = rx_zero & ~RX_I;
                    next_rx_idx  = rx_idx + 3'h1;
                    if (rx_idx == 3'h7)
                    begin
                        next_rx_state = (ctrl_par == parity_none) ? R_STOP : R_PAR;
                    end
                end
            end
            R_PAR:
            begin
                if (rx_tick)
                begin
                    next_rx_perr  = (RX_I != parity_bit(ctrl_par, rx_sh));
                    next_rx_zero  = rx_zero & ~RX_I;
                    next_rx_state = R_STOP;
                end
            end
            R_STOP:
            begin
                if (rx_tick)
                begin
                    rx_deliver                 = 1'b1;
                    rx_errs[rx_framing_error]  = ~RX_I;
                    rx_errs[rx_parity_error]   = rx_perr;
                    rx_errs[rx_break_error]    = rx_zero & ~RX_I;
                    next_rx_state              = R_IDLE;
                end
            end
            default: next_rx_state = R_IDLE;
        endcase
    end

    always_ff @(posedge CLK_I)
    begin
        if (RESET_I)
        begin
            rx_state <= R_IDLE;
            rx_cnt   <= 16'h0000;
            rx_idx   <= 3'h0;
            rx_sh    <= 8'h00;
            rx_zero  <= 1'b0;
            rx_perr  <= 1'b0;
            rx_prev  <= 1'b1;
        end
        else
        begin
            rx_state <= next_rx_state;
            rx_cnt   <= next_rx_cnt;
            rx_idx   <= next_rx_idx;
            rx_sh    <= next_rx_sh;
            rx_zero  <= next_rx_zero;
            rx_perr  <= next_rx_perr;
            rx_prev  <= RX_I;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);

    chk_forced_one: assert property
        (tx_state == T_LOAD && ctrl_par == parity_forced_one |=> tx_parb && tx_paron)
        else $error("forced one parity bit not high");
    chk_no_parity: assert property
        (tx_state == T_DATA && tx_cnt == 16'h0000 && tx_idx == 3'h7 && !tx_paron
        |=> tx_state == T_STOP && TX_O) else $error("parity slot sent with none");
    chk_overrun_now: assert property
        (rx_deliver && rx_full && !rx_pop |=> rxerr[rx_overrun_error] && rx_full)
        else $error("overrun flag not set at once");
    chk_err_clear: assert property (wr_rxerr && !rx_deliver |=> rxerr == 4'h0)
        else $error("error flags not cleared");
    chk_char_parity: assert property
        (rx_deliver && !rx_full && rx_errs[rx_parity_error]
        |=> rx_herr[rx_parity_error] && rxerr[rx_parity_error])
        else $error("parity error lost");
    chk_eot_int: assert property
        ($rose(ris[INT_TX]) && $past(txint_mode) == txint_end_of_transmission
        |-> $past(tx_state) == T_STOP && $past(count) == 5'h00)
        else $error("early eot interrupt");
    chk_fifo_int: assert property
        ($rose(ris[INT_TX]) && $past(txint_mode) == txint_fifo_level
        |-> $past(count) > {1'b0, $past(thr)})
        else $error("tx level interrupt off threshold");
    chk_irq_mask: assert property ((ris & ien) == 6'h00 |-> !IRQ_O)
        else $error("interrupt raised while masked");
    chk_full_hold: assert property (count == FIFO_DEPTH && !tx_pop |=> count == FIFO_DEPTH)
        else $error("full fifo accepted a character");

    cov_overrun:   cover property (overrun);
    cov_parity:    cover property (rx_deliver && rx_errs[rx_parity_error]);
    cov_eot:       cover property (tx_done && txint_mode == txint_end_of_transmission);
    cov_full:      cover property (count == FIFO_DEPTH);

endmodule : uart_port

// ### hdl/uart_pkg.sv
// constants and types shared by the serial port design files
package uart_pkg;

    // register byte offsets
    localparam logic [7:0] ADDR_DATA  = 8'h00;
    localparam logic [7:0] ADDR_RXERR = 8'h04;
    localparam logic [7:0] ADDR_CTRL  = 8'h08;
    localparam logic [7:0] ADDR_BAUD  = 8'h0C;
    localparam logic [7:0] ADDR_FLAG  = 8'h10;
    localparam logic [7:0] ADDR_THR   = 8'h14;
    localparam logic [7:0] ADDR_RIS   = 8'h18;
    localparam logic [7:0] ADDR_IEN   = 8'h1C;
    localparam logic [7:0] ADDR_MIS   = 8'h20;
    localparam logic [7:0] ADDR_ICLR  = 8'h24;

    // control field positions
    localparam int CTRL_PAR_LSB = 0;
    localparam int CTRL_SMART   = 3;
    localparam int CTRL_TXINT   = 4;

    // receiver error bit positions
    localparam int rx_framing_error = 0;
    localparam int rx_parity_error  = 1;
    localparam int rx_break_error   = 2;
    localparam int rx_overrun_error = 3;

    // interrupt bit positions
    localparam int INT_RX = 0;
    localparam int INT_TX = 1;
    localparam int INT_FE = 2;
    localparam int INT_PE = 3;
    localparam int INT_BE = 4;
    localparam int INT_OE = 5;

    // reset values and sizes
    localparam logic [15:0] BAUD_RESET = 16'h0364;
    localparam logic [3:0]  THR_RESET  = 4'h8;
    localparam int          FIFO_AW    = 4;
    localparam logic [4:0]  FIFO_DEPTH = 5'h10;

    typedef enum logic [2:0] {
        parity_none        = 3'b000,
        parity_even        = 3'b001,
        parity_odd         = 3'b010,
        parity_forced_one  = 3'b011,
        parity_forced_zero = 3'b100
    } parity_type;

    typedef enum logic {
        txint_fifo_level          = 1'b0,
        txint_end_of_transmission = 1'b1
    } txint_type;

endpackage : uart_pkg

// ### hdl/uart_tx_mem.sv
// transmit character storage with registered read data
`timescale 1ns/100ps
module uart_tx_mem
    import uart_pkg::*;
(
    // clock
    input  wire logic               clk_i,
    // write port
    input  wire logic               we_i,
    input  wire logic [FIFO_AW-1:0] waddr_i,
    input  wire logic [7:0]         wdata_i,
    // read port
    input  wire logic [FIFO_AW-1:0] raddr_i,
    output logic      [7:0]         rdata_o
);

    logic [7:0] mem [0:(1<<FIFO_AW)-1];

    always_ff @(posedge clk_i)
    begin
        if (we_i)
        begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end

endmodule : uart_tx_mem

// ### tb/uart_remote.sv
// remote serial transmitter and receiver: drives the port's receive line and samples its transmit line
`timescale 1ns/100ps
module uart_remote #(parameter int BIT_CLKS = 4)
(
    // clock
    input  wire logic clk_i,
    // serial line
    input  wire logic line_i,
    output logic      line_o
);
    initial line_o = 1'b1;
    task automatic send(input logic [7:0] d, input logic p, input logic with_par,
                        input logic s);
        logic [10:0] f;
        f = {s, p, d, 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            if (i != 9 || with_par)
            begin
                line_o <= f[i];
                repeat (BIT_CLKS) @(posedge clk_i);
            end
        end
        line_o <= 1'b1;
        repeat (BIT_CLKS) @(posedge clk_i);
    endtask : send
    task automatic recv(output logic [10:0] f);
        int n = 0;
        while (line_i !== 1'b0 && n < 2000)
        begin
            @(posedge clk_i);
            n++;
        end
        repeat (BIT_CLKS / 2) @(posedge clk_i);
        for (int i = 0; i < 11; i++)
        begin
            f[i] = line_i;
            repeat (BIT_CLKS) @(posedge clk_i);
        end
    endtask : recv
endmodule : uart_remote

// ### tb/uart_parity_error_txint_tb_top.sv
// self-checking bench for the serial port core
`timescale 1ns/100ps
module uart_parity_error_txint_tb_top
    import uart_pkg::*;
;
    logic        CLK_I = 1'b0, RESET_I = 1'b1, HWRITE_I = 1'b0;
    logic [1:0]  HTRANS_I = 2'h0;
    logic [31:0] HADDR_I = 32'h0, HWDATA_I = 32'h0, HRDATA_O, rdv;
    logic        RX_I, TX_O, IRQ_O, HREADYOUT_O, HRESP_O;
    int          fail_count = 0, cmp_count = 0;
    uart_port dut (.CLK_I(CLK_I), .RESET_I(RESET_I), .HSEL_I(1'b1), .HADDR_I(HADDR_I),
        .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HSIZE_I(3'h2), .HWDATA_I(HWDATA_I),
        .HREADY_I(HREADYOUT_O), .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O),
        .HRESP_O(HRESP_O), .RX_I(RX_I), .TX_O(TX_O), .IRQ_O(IRQ_O));
    uart_remote remote (.clk_i(CLK_I), .line_i(TX_O), .line_o(RX_I));
    initial forever #5 CLK_I = ~CLK_I;
    task automatic final_report;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            $display("wrong value %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask : chk
    task automatic step;
        int n = 0;
        do
        begin
            @(posedge CLK_I);
            n++;
        end
        while (HREADYOUT_O !== 1'b1 && n < 9);
        if (HREADYOUT_O !== 1'b1)
        begin
            fail_count++;
            final_report();
        end
    endtask : step
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        HTRANS_I <= 2'h2;
        HWRITE_I <= w;
        HADDR_I <= {24'h0, a};
        step();
        HTRANS_I <= 2'h0;
        HWDATA_I <= d;
        step();
        rdv = HRDATA_O;
        chk("hresp", 32'h0, {31'h0, HRESP_O});
    endtask : bus
    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        @(posedge CLK_I);
        bus(1'b0, a, 32'h0);
        chk(n, e, rdv);
    endtask : rdc
    task automatic poll(input logic [7:0] a, input int b);
        int n = 0;
        do
        begin
            bus(1'b0, a, 32'h0);
            n++;
        end
        while (rdv[b] !== 1'b1 && n < 600);
        chk("poll bit", 32'h1, {31'h0, rdv[b]});
        if (rdv[b] !== 1'b1)
            final_report();
    endtask : poll
    initial
    begin
        parity_type pm[5] = '{parity_even, parity_odd, parity_forced_one,
                              parity_forced_zero, parity_none};
        logic [4:0] good = 5'b00110;
        logic err;
        logic [10:0] frame;
        repeat (4) @(posedge CLK_I);
        RESET_I <= 1'b0;
        rdc("ctrl reset", ADDR_CTRL, 32'h0);
        rdc("flag reset", ADDR_FLAG, 32'h3);
        bus(1'b1, ADDR_BAUD, 32'h4);
        for (int j = 0; j < 2; j++)
        begin
            bus(1'b1, ADDR_CTRL, {29'h0, pm[2 + j]});
            bus(1'b1, ADDR_DATA, {24'h0, 8'h5A + 8'(j)});
            remote.recv(frame);
            chk("tx frame", {21'h0, 2'b11 ^ 2'(j), 8'h5A + 8'(j), 1'b0}, {21'h0, frame});
        end
        $display("transmit test done");
        for (int i = 0; i < 10; i++)
        begin
            err = i[0] && i < 8;
            bus(1'b1, ADDR_CTRL, {29'h0, pm[i/2]});
            rdc("parity mode", ADDR_CTRL, {29'h0, pm[i/2]});
            remote.send(8'hA5, good[i/2] ^ err, pm[i/2] != parity_none, 1'b1);
            poll(ADDR_FLAG, 3);
            rdc("rx errors", ADDR_RXERR, {30'h0, err, 1'b0});
            rdc("rx char", ADDR_DATA, {22'h0, err, 9'h0A5});
            bus(1'b1, ADDR_RXERR, 32'h0);
            rdc("rx clear", ADDR_RXERR, 32'h0);
        end
        $display("parity test done");
        remote.send(8'h00, 1'b0, 1'b0, 1'b0);
        poll(ADDR_FLAG, 3);
        rdc("break flags", ADDR_RXERR, 32'h5);
        rdc("break char", ADDR_DATA, 32'h500);
        bus(1'b1, ADDR_RXERR, 32'h0);
        $display("break test done");
        remote.send(8'h3C, 1'b0, 1'b0, 1'b1);
        remote.send(8'hC3, 1'b0, 1'b0, 1'b1);
        rdc("overrun flag", ADDR_RXERR, 32'h8);
        rdc("overrun char", ADDR_DATA, 32'h83C);
        bus(1'b1, ADDR_RXERR, 32'h0);
        $display("overrun test done");
        bus(1'b1, ADDR_BAUD, 32'h8);
        bus(1'b1, ADDR_ICLR, 32'h3F);
        bus(1'b1, ADDR_IEN, 32'h2);
        for (int i = 0; i < 18; i++)
            bus(1'b1, ADDR_DATA, 32'(i));
        rdc("tx full", ADDR_FLAG, 32'h104);
        poll(ADDR_RIS, INT_TX);
        rdc("masked", ADDR_MIS, 32'h2);
        chk("irq high", 32'h1, {31'h0, IRQ_O});
        bus(1'b1, ADDR_ICLR, 32'h2);
        rdc("raw cleared", ADDR_RIS, 32'h0);
        chk("irq low", 32'h0, {31'h0, IRQ_O});
        $display("fifo test done");
        bus(1'b1, ADDR_CTRL, 32'h9);
        rdc("smart on", ADDR_CTRL, 32'h9);
        bus(1'b1, ADDR_CTRL, 32'h10);
        rdc("txint mode", ADDR_CTRL, 32'h10);
        poll(ADDR_RIS, INT_TX);
        rdc("eot idle", ADDR_FLAG, 32'h3);
        $display("eot test done");
        final_report();
    end
endmodule : uart_parity_error_txint_tb_top
